// [design/ldm_defs.vh]
// Purpose: Constants for the dimming mode controller
// Assumes: 50 MHz system clock
// Notes: Register offsets are byte addresses on the Avalon-MM slave
`ifndef LDM_DEFS_VH
`define LDM_DEFS_VH

// Clock and times
`define LDM_CLK_HZ 50000000
`define LDM_DELAY_US 500
`define LDM_DELAY_CYC ((`LDM_DELAY_US * (`LDM_CLK_HZ / 1000000)))
`define LDM_RATE_LO_HZ 200
`define LDM_RATE_HI_HZ 23000
// Chopping period split into 256 steps, so a step is period/256
`define LDM_STEP_LO (`LDM_CLK_HZ / (`LDM_RATE_LO_HZ * 256))
`define LDM_STEP_HI (`LDM_CLK_HZ / (`LDM_RATE_HI_HZ * 256))

// Mode pin decoded levels
`define LDM_PIN_LOW 2'h0
`define LDM_PIN_MID 2'h1
`define LDM_PIN_HIGH 2'h2
`define LDM_PIN_FLOAT 2'h3

// Modes
`define LDM_MODE_MIX 2'h0
`define LDM_MODE_PWM 2'h1
`define LDM_MODE_ANA 2'h2

// Duty scale: 12 bits, full scale 4095
`define LDM_DW 12
`define LDM_FULL 12'hfff
`define LDM_QUARTER 12'h400
`define LDM_TP_HI 12'h400
`define LDM_TP_LO 12'h200
`define LDM_LOWDUTY 12'h19a
`define LDM_HYST 12'h014

// Registers
`define LDM_REG_CTRL 4'h0
`define LDM_REG_STAT 4'h4
`define LDM_REG_DUTY 4'h8
`define LDM_REG_AMP 4'hc
`define LDM_CTRL_MODE_LSB 0
`define LDM_CTRL_TP_BIT 2
`define LDM_CTRL_RATE_BIT 3
`define LDM_CTRL_RESET 4'h0

// Start-up states
`define LDM_ST_W 3
`define LDM_ST_DISC 3'h0
`define LDM_ST_WAIT 3'h1
`define LDM_ST_CHECK 3'h2
`define LDM_ST_SAFE 3'h3
`define LDM_ST_SOFT 3'h4
`define LDM_ST_RUN 3'h5
`define LDM_ST_LATCH 3'h6

`define LDM_SOFT_STEP 12'h010
`define LDM_CNT_W 24
`define LDM_CNT_MAX 24'hffffff
`define LDM_DIV_LAST 5'h0b
`endif

// [design/ldm_duty_meter.v]
// Purpose: Measures high time and period of the dimming input
// Assumes: Input is synchronous to clk
// Notes: Duty result is high/period scaled to 12 bits
`timescale 1ns/100ps
`include "ldm_defs.vh"

module ldm_duty_meter (
  input wire clk,
  input wire rstn,
  input wire dim_in,
  output reg [`LDM_DW-1:0] duty_reg,
  output reg valid_reg
);

  reg dim_d_reg;
  reg [`LDM_CNT_W-1:0] high_reg;
  reg [`LDM_CNT_W-1:0] per_reg;
  reg [`LDM_CNT_W-1:0] hi_lat_reg;
  reg [`LDM_CNT_W-1:0] per_lat_reg;
  reg [`LDM_CNT_W-1:0] quot_reg;
  reg [`LDM_CNT_W-1:0] rem_reg;
  reg [4:0] bit_reg;
  reg busy_reg;
  wire rise;
  wire [`LDM_CNT_W:0] trial;

  assign rise = dim_in & ~dim_d_reg;
  assign trial = {rem_reg, 1'b0} - {1'b0, per_lat_reg};

  // ----------------------------------------------------------------
  // Counting, one result per rising edge
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dim_d_reg <= 1'b0;
      high_reg <= {`LDM_CNT_W{1'b0}};
      per_reg <= {`LDM_CNT_W{1'b0}};
      hi_lat_reg <= {`LDM_CNT_W{1'b0}};
      per_lat_reg <= {`LDM_CNT_W{1'b0}};
      quot_reg <= {`LDM_CNT_W{1'b0}};
      rem_reg <= {`LDM_CNT_W{1'b0}};
      bit_reg <= 5'h0;
      busy_reg <= 1'b0;
      duty_reg <= {`LDM_DW{1'b0}};
      valid_reg <= 1'b0;
    end else begin
      dim_d_reg <= dim_in;
      valid_reg <= 1'b0;
      if (rise) begin // [R20]
        hi_lat_reg <= high_reg;
        per_lat_reg <= per_reg;
        rem_reg <= high_reg;
        quot_reg <= {`LDM_CNT_W{1'b0}};
        bit_reg <= 5'h0;
        busy_reg <= (per_reg != {`LDM_CNT_W{1'b0}});
        high_reg <= 24'h000001;
        per_reg <= 24'h000001;
      end else begin
        // Saturate so a stuck input never wraps into a bogus duty
        if (per_reg != `LDM_CNT_MAX) begin
          per_reg <= per_reg + 24'h000001;
          if (dim_in) begin
            high_reg <= high_reg + 24'h000001;
          end
        end
      end
      // Serial restoring divide: 12 quotient bits, 12 cycles
      if (busy_reg && !rise) begin // [R10] [R13]
        if (!trial[`LDM_CNT_W]) begin
          rem_reg <= trial[`LDM_CNT_W-1:0];
          quot_reg <= {quot_reg[`LDM_CNT_W-2:0], 1'b1};
        end else begin
          rem_reg <= {rem_reg[`LDM_CNT_W-2:0], 1'b0};
          quot_reg <= {quot_reg[`LDM_CNT_W-2:0], 1'b0};
        end
        bit_reg <= bit_reg + 5'h01;
        if (bit_reg == `LDM_DIV_LAST) begin
          busy_reg <= 1'b0;
          valid_reg <= 1'b1;
          if (hi_lat_reg >= per_lat_reg) begin
            duty_reg <= `LDM_FULL;
          end else if (!trial[`LDM_CNT_W]) begin
            duty_reg <= {quot_reg[`LDM_DW-2:0], 1'b1};
          end else begin
            duty_reg <= {quot_reg[`LDM_DW-2:0], 1'b0};
          end
        end
      end
    end
  end

endmodule // ldm_duty_meter

// [design/ldm_dimming_ctrl.v]
// Purpose: Dimming mode selection, amplitude/chopping and start-up sequence
// Assumes: All inputs synchronous to clk; mode pin arrives pre-decoded
// Notes: Avalon-MM slave, one wait state per access
// What this block does
// R1 - Low mode pin selects mixed dimming
// R2 - Middle mode pin selects direct PWM
// R3 - High mode pin selects analog dimming
// R4 - Floating pin: mode field picks mode
// R5 - Mixed transfer point selectable, two values
// R6 - Mixed above point: amplitude follows duty
// R7 - Mixed below: quarter amplitude, 4x chop duty
// R8 - Mixed chop rate register-selected, input-independent
// R9 - Direct PWM: full amplitude, gated by input
// R10 - Analog: amplitude is full scale times duty
// R11 - Host keeps analog PWM 100Hz to 20kHz
// R12 - Analog duty under 10% raises headroom
// R13 - Resolve at least 200:1 dimming ratio
// R14 - Drive disconnect, wait 500us, then check
// R15 - Output sense under 100mV latches off
// R16 - Boost with soft start after checks pass
// R17 - Host order: supply, enable, config, PWM
// R18 - Transfer select zero gives 25 percent
// R19 - Rate select zero gives 200 Hz
// R20 - Count high and period, update each rise
`timescale 1ns/100ps
`include "ldm_defs.vh"

module ldm_dimming_ctrl (
  input wire clk,
  input wire rstn,
  // Avalon-MM slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire [1:0] avs_response,
  // Pins, already decoded
  input wire [1:0] mode_pin_level,
  input wire dim_in,
  input wire output_short_low,
  input wire safety_ok,
  // Analog and power side
  output reg input_disconnect_drive,
  output reg boost_enable,
  output reg [`LDM_DW-1:0] amplitude,
  output reg channel_gate,
  output reg headroom_raise,
  output reg latched_off
);

  // ----------------------------------------------------------------
  // Registers and bus
  // ----------------------------------------------------------------
  reg [1:0] dimming_mode_field;
  reg transfer_point_select;
  reg mixed_output_rate_select;
  reg ack_reg;
  reg resp_err_reg;
  wire access;
  wire [`LDM_DW-1:0] duty;
  wire duty_valid;

  assign access = avs_read | avs_write;
  // One wait state; request is done on the edge where ack_reg is high
  assign avs_waitrequest = access & ~ack_reg;
  assign avs_response = resp_err_reg ? 2'h2 : 2'h0;

  reg [1:0] mode_reg;
  reg [`LDM_ST_W-1:0] st_reg;
  reg [`LDM_DW-1:0] soft_reg;

  // ----------------------------------------------------------------
  // Readback words
  // ----------------------------------------------------------------
  wire [31:0] ctrl_word;
  wire [31:0] stat_word;
  assign ctrl_word = {28'h0, mixed_output_rate_select, transfer_point_select,
                      dimming_mode_field};
  assign stat_word = {24'h0, headroom_raise, latched_off, mode_reg, 1'b0, st_reg};

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      resp_err_reg <= 1'b0;
      avs_readdata <= 32'h0;
      dimming_mode_field <= `LDM_MODE_MIX;
      transfer_point_select <= 1'b0;
      mixed_output_rate_select <= 1'b0;
    end else begin
      ack_reg <= access & ~ack_reg;
      if (access && !ack_reg) begin
        resp_err_reg <= 1'b0;
        avs_readdata <= 32'h0;
        case (avs_address)
          `LDM_REG_CTRL: begin
            avs_readdata <= ctrl_word;
          end
          `LDM_REG_STAT: begin
            avs_readdata <= stat_word;
          end
          `LDM_REG_DUTY: begin
            avs_readdata <= {20'h0, duty};
          end
          `LDM_REG_AMP: begin
            avs_readdata <= {20'h0, amplitude};
          end
          default: begin
            resp_err_reg <= 1'b1;
          end
        endcase
      end
      // Writes land on the edge where the master sees waitrequest low
      if (access && ack_reg && avs_write && avs_byteenable[0] &&
          avs_address == `LDM_REG_CTRL) begin
        dimming_mode_field <= avs_writedata[`LDM_CTRL_MODE_LSB+1:`LDM_CTRL_MODE_LSB];
        transfer_point_select <= avs_writedata[`LDM_CTRL_TP_BIT];
        mixed_output_rate_select <= avs_writedata[`LDM_CTRL_RATE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Duty measurement
  // ----------------------------------------------------------------
  // Duty is held between updates, so every user sees one value per period
  ldm_duty_meter u_meter (
    .clk(clk),
    .rstn(rstn),
    .dim_in(dim_in),
    .duty_reg(duty),
    .valid_reg(duty_valid)
  );

  // ----------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------
  // The pin wins; only a floating pin hands the choice to the field
  reg [1:0] mode_next;
  always @* begin
    case (mode_pin_level)
      `LDM_PIN_LOW: mode_next = `LDM_MODE_MIX; // [R1]
      `LDM_PIN_MID: mode_next = `LDM_MODE_PWM; // [R2]
      `LDM_PIN_HIGH: mode_next = `LDM_MODE_ANA; // [R3]
      default: begin
        // Code 11 of the field is unlisted; treat it as mixed
        if (dimming_mode_field == `LDM_MODE_PWM || dimming_mode_field == `LDM_MODE_ANA) begin
          mode_next = dimming_mode_field; // [R4]
        end else begin
          mode_next = `LDM_MODE_MIX; // [R4]
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Mixed-mode transfer point with hysteresis
  // ----------------------------------------------------------------
  wire [`LDM_DW-1:0] tp;
  wire [`LDM_DW:0] duty_hyst;
  wire below_now;
  reg below_reg;
  assign tp = transfer_point_select ? `LDM_TP_LO : `LDM_TP_HI; // [R5] [R18]
  // One bit wider so a duty near full scale cannot wrap below the point
  assign duty_hyst = {1'b0, duty} + {1'b0, `LDM_HYST};
  // Hysteresis stops toggling near the point; judged from the live duty so the
  // amplitude never pairs a fresh duty with a stale side for a cycle
  assign below_now = below_reg ? (duty <= tp) : (duty_hyst < {1'b0, tp}); // [R6] [R7]

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      below_reg <= 1'b1;
      mode_reg <= `LDM_MODE_MIX;
    end else begin
      mode_reg <= mode_next;
      if (duty_valid) begin
        below_reg <= below_now;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mixed-mode chopping generator, independent of input frequency
  // ----------------------------------------------------------------
  reg [15:0] step_cnt_reg;
  reg [7:0] phase_reg;
  wire [15:0] step_len;
  wire step_tick;
  wire [13:0] duty_x4;
  wire [7:0] chop_duty;
  wire chop_out;

  wire [31:0] step_lo_full;
  wire [31:0] step_hi_full;

  // The chop phase runs off clk alone, so its rate never follows the input
  assign step_lo_full = `LDM_STEP_LO;
  assign step_hi_full = `LDM_STEP_HI;
  assign step_len = mixed_output_rate_select ? step_hi_full[15:0] : // [R8] [R19]
                    step_lo_full[15:0];
  assign step_tick = (step_cnt_reg >= step_len - 16'h0001);
  assign duty_x4 = {duty, 2'b00}; // [R7]
  // An input at a quarter or more saturates the chop duty at its top step
  assign chop_duty = (duty_x4[13:12] != 2'b00) ? 8'hff : duty_x4[11:4];
  assign chop_out = (phase_reg < chop_duty);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      step_cnt_reg <= 16'h0;
      phase_reg <= 8'h0;
    end else if (step_tick) begin
      step_cnt_reg <= 16'h0;
      phase_reg <= phase_reg + 8'h01;
    end else begin
      step_cnt_reg <= step_cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Start-up sequence
  // ----------------------------------------------------------------
  reg [`LDM_CNT_W-1:0] wait_reg;
  wire [31:0] wait_last;
  // Last count of the wait, so the check comes exactly one delay after it began
  assign wait_last = `LDM_DELAY_CYC - 1;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= `LDM_ST_DISC;
      wait_reg <= {`LDM_CNT_W{1'b0}};
      soft_reg <= {`LDM_DW{1'b0}};
      input_disconnect_drive <= 1'b0;
      boost_enable <= 1'b0;
      latched_off <= 1'b0;
    end else begin
      case (st_reg)
        `LDM_ST_DISC: begin
          input_disconnect_drive <= 1'b1; // [R14]
          wait_reg <= {`LDM_CNT_W{1'b0}};
          st_reg <= `LDM_ST_WAIT;
        end
        `LDM_ST_WAIT: begin
          wait_reg <= wait_reg + 24'h000001;
          if (wait_reg == wait_last[`LDM_CNT_W-1:0]) begin // [R14]
            st_reg <= `LDM_ST_CHECK;
          end
        end
        `LDM_ST_CHECK: begin
          if (output_short_low) begin // [R15]
            st_reg <= `LDM_ST_LATCH;
          end else begin
            st_reg <= `LDM_ST_SAFE;
          end
        end
        `LDM_ST_SAFE: begin
          // Holds here for as long as any other start-up check still fails
          if (safety_ok) begin // [R16]
            st_reg <= `LDM_ST_SOFT;
            boost_enable <= 1'b1;
            soft_reg <= {`LDM_DW{1'b0}};
          end
        end
        `LDM_ST_SOFT: begin
          // Ramp the amplitude ceiling so the boost starts gently
          if (soft_reg >= `LDM_FULL - `LDM_SOFT_STEP) begin // [R16]
            soft_reg <= `LDM_FULL;
            st_reg <= `LDM_ST_RUN;
          end else begin
            soft_reg <= soft_reg + `LDM_SOFT_STEP;
          end
        end
        `LDM_ST_RUN: begin
          soft_reg <= `LDM_FULL;
        end
        `LDM_ST_LATCH: begin
          // Only enable (reset) leaves the latched-off state
          latched_off <= 1'b1; // [R15]
          boost_enable <= 1'b0;
          input_disconnect_drive <= 1'b0;
        end
        default: begin
          st_reg <= `LDM_ST_DISC;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Amplitude and gate per mode
  // ----------------------------------------------------------------
  reg [`LDM_DW-1:0] amp_next;
  reg gate_next;
  always @* begin
    case (mode_reg)
      `LDM_MODE_PWM: begin
        amp_next = `LDM_FULL; // [R9]
        gate_next = dim_in; // [R9]
      end
      `LDM_MODE_ANA: begin
        amp_next = duty; // [R10] [R13]
        gate_next = 1'b1;
      end
      default: begin
        if (below_now) begin
          amp_next = `LDM_QUARTER; // [R7]
          gate_next = chop_out; // [R7] [R8]
        end else begin
          amp_next = duty; // [R6]
          gate_next = 1'b1;
        end
      end
    endcase
    // Clip to the soft-start ceiling; after the ramp this is full scale
    if (amp_next > soft_reg) begin
      amp_next = soft_reg;
    end
  end

  wire running;
  // Nothing reaches the channels before boosting starts or after a latch
  assign running = boost_enable & ~latched_off;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      amplitude <= {`LDM_DW{1'b0}};
      channel_gate <= 1'b0;
      headroom_raise <= 1'b0;
    end else begin
      amplitude <= running ? amp_next : {`LDM_DW{1'b0}};
      channel_gate <= running & gate_next;
      headroom_raise <= (mode_reg == `LDM_MODE_ANA) && (duty < `LDM_LOWDUTY); // [R12]
    end
  end

endmodule // ldm_dimming_ctrl

// [bench/ldm_dimming_ctrl_properties.sv]
// Purpose: Port-level timing checks for the dimming controller
// Assumes: One clk domain, rstn asynchronous and active low
// Notes: Helper counters saturate so long runs stay bounded
`timescale 1ns/100ps
`include "ldm_defs.vh"
module ldm_props (
  input wire clk,
  input wire rstn,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [1:0] avs_response,
  input wire [1:0] mode_pin_level,
  input wire dim_in,
  input wire output_short_low,
  input wire safety_ok,
  input wire input_disconnect_drive,
  input wire boost_enable,
  input wire [`LDM_DW-1:0] amplitude,
  input wire channel_gate,
  input wire headroom_raise,
  input wire latched_off
);
  logic [15:0] up_cnt;
  logic [8:0] on_cnt;
  wire run = on_cnt > 9'h12c;
  // Run means the soft ramp is surely over, so targets are final
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      up_cnt <= 16'h0;
      on_cnt <= 9'h0;
    end else begin
      if (up_cnt != 16'hffff) up_cnt <= up_cnt + 16'h1;
      if (!boost_enable) on_cnt <= 9'h0;
      else if (on_cnt != 9'h1ff) on_cnt <= on_cnt + 9'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_bus_one_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("bus late");
  a_delay_first: assert property (
    boost_enable |-> up_cnt >= 16'h61a8) else $error("boost before delay");
  a_disc_first: assert property (
    boost_enable |-> input_disconnect_drive) else $error("boost without disconnect");
  a_latch_sticky: assert property (
    latched_off |=> latched_off && !boost_enable) else $error("latch released");
  a_latch_cause: assert property (
    $rose(latched_off) |-> $past(output_short_low, 2)) else $error("latch without short");
  a_safety_gate: assert property (
    !safety_ok [*3] |-> !$rose(boost_enable)) else $error("boost without checks");
  a_soft_ramp: assert property (
    boost_enable && !run |-> {1'b0, amplitude} <= {1'b0, $past(amplitude)} + 13'h010)
    else $error("ramp too steep");
  a_pwm_full: assert property (
    (run && mode_pin_level == `LDM_PIN_MID) [*4] |-> amplitude == `LDM_FULL)
    else $error("pwm amplitude not full");
  a_pwm_gate: assert property (
    run && mode_pin_level == `LDM_PIN_MID && $rose(dim_in) |-> ##[1:4] channel_gate)
    else $error("gate missed pulse");
  a_mix_floor: assert property (
    (run && mode_pin_level == `LDM_PIN_LOW) [*4] |-> amplitude >= 12'h1ec)
    else $error("mixed amplitude too low");
  a_no_headroom: assert property (
    (mode_pin_level == `LDM_PIN_LOW || mode_pin_level == `LDM_PIN_MID) [*4] |-> !headroom_raise)
    else $error("headroom outside analog");
  cover property ($rose(latched_off));
  cover property ($rose(boost_enable));
  cover property (run && headroom_raise);
endmodule // ldm_props
bind ldm_dimming_ctrl ldm_props u_props (.clk(clk), .rstn(rstn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .mode_pin_level(mode_pin_level), .dim_in(dim_in), .output_short_low(output_short_low),
  .safety_ok(safety_ok), .input_disconnect_drive(input_disconnect_drive),
  .boost_enable(boost_enable), .amplitude(amplitude), .channel_gate(channel_gate),
  .headroom_raise(headroom_raise), .latched_off(latched_off));

// [bench/ldm_host_pwm.sv]
// Purpose: Host side dimming PWM source
// Assumes: Period and high time given in clk cycles
// Notes: A zero period keeps the line low, so no PWM before configuration
`timescale 1ns/100ps
module ldm_host_pwm (
  input wire clk,
  input wire rstn,
  input wire [15:0] high_cyc,
  input wire [15:0] per_cyc,
  output logic dim_in
);
  logic [15:0] pos;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pos <= 16'h0;
      dim_in <= 1'b0;
    end else begin
      pos <= (pos + 16'h1 >= per_cyc) ? 16'h0 : pos + 16'h1;
      dim_in <= (per_cyc != 16'h0) && (pos < high_cyc);
    end
  end
endmodule // ldm_host_pwm

// [bench/ldm_dimming_ctrl_bench.sv]
// Purpose: Self-checking bench for the dimming controller
// Assumes: 50 MHz clk; start-up wait is fixed inside the design
// Notes: Analog rows use a 20 kHz input, the fastest the host may send
`timescale 1ns/100ps
`include "ldm_defs.vh"
module ldm_dimming_ctrl_bench;
  typedef struct packed {
    logic [1:0] pin;
    logic [3:0] ctrl;
    logic [15:0] hi;
    logic [15:0] per;
    logic [11:0] lo_a;
    logic [11:0] hi_a;
    logic [1:0] mode;
    logic hr;
  } ldm_row_t;
  ldm_row_t rows [10] = '{
    '{2'h0, 4'h0, 16'h00c8, 16'h0190, 12'h7f0, 12'h80f, 2'h0, 1'b0},
    '{2'h1, 4'h0, 16'h00c8, 16'h0190, 12'hfff, 12'hfff, 2'h1, 1'b0},
    '{2'h0, 4'h0, 16'h0028, 16'h0190, 12'h400, 12'h400, 2'h0, 1'b0},
    '{2'h0, 4'h4, 16'h0050, 16'h0190, 12'h32b, 12'h33b, 2'h0, 1'b0},
    '{2'h0, 4'h4, 16'h0028, 16'h0190, 12'h400, 12'h400, 2'h0, 1'b0},
    '{2'h3, 4'h0, 16'h00c8, 16'h0190, 12'h7f0, 12'h80f, 2'h0, 1'b0},
    '{2'h3, 4'h1, 16'h00c8, 16'h0190, 12'hfff, 12'hfff, 2'h1, 1'b0},
    '{2'h3, 4'h2, 16'h04e2, 16'h09c4, 12'h7f0, 12'h80f, 2'h2, 1'b0},
    '{2'h2, 4'h0, 16'h007d, 16'h09c4, 12'h0c4, 12'h0d4, 2'h2, 1'b1},
    '{2'h2, 4'h0, 16'h000c, 16'h09c4, 12'h00c, 12'h01c, 2'h2, 1'b1}};
  logic clk = 0;
  logic rstn = 0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire [1:0] avs_response;
  logic [1:0] mode_pin_level = 2'h0;
  wire dim_in;
  logic output_short_low = 0;
  logic safety_ok = 0;
  wire input_disconnect_drive;
  wire boost_enable;
  wire [`LDM_DW-1:0] amplitude;
  wire channel_gate;
  wire headroom_raise;
  wire latched_off;
  logic [15:0] high_cyc = 16'h0;
  logic [15:0] per_cyc = 16'h0;
  logic [31:0] got;
  logic [1:0] resp_got;
  int fails = 0;
  int n_compared = 0;
  int c;
  always #10 clk = ~clk;
  ldm_dimming_ctrl u_dut (.clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .mode_pin_level(mode_pin_level), .dim_in(dim_in),
    .output_short_low(output_short_low), .safety_ok(safety_ok),
    .input_disconnect_drive(input_disconnect_drive), .boost_enable(boost_enable),
    .amplitude(amplitude), .channel_gate(channel_gate), .headroom_raise(headroom_raise),
    .latched_off(latched_off));
  ldm_host_pwm u_host (.clk(clk), .rstn(rstn), .high_cyc(high_cyc), .per_cyc(per_cyc),
    .dim_in(dim_in));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  task end_of_test();
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    got = avs_readdata;
    resp_got = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task gate_count(input int n);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      if (channel_gate === 1'b1) c++;
    end
  endtask
  // Safety checks are held failing past the delay to prove they gate boosting
  task start(input logic sh);
    output_short_low <= sh;
    safety_ok <= 1'b0;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk(input_disconnect_drive, 1);
    repeat (25100) @(posedge clk);
    chk(boost_enable, 0);
    chk(latched_off, sh);
    safety_ok <= 1'b1;
    repeat (400) @(posedge clk);
    chk(boost_enable, !sh);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    end_of_test();
  end
  initial begin
    start(1'b0);
    bus(0, `LDM_REG_CTRL, 32'h0);
    chk(got[3:0], `LDM_CTRL_RESET);
    foreach (rows[i]) begin
      mode_pin_level <= rows[i].pin;
      bus(1, `LDM_REG_CTRL, {28'h0, rows[i].ctrl});
      high_cyc <= rows[i].hi;
      per_cyc <= rows[i].per;
      repeat (2 * rows[i].per + 400) @(posedge clk);
      bus(0, `LDM_REG_AMP, 32'h0);
      chk(got[11:0] >= rows[i].lo_a && got[11:0] <= rows[i].hi_a, 1);
      bus(0, `LDM_REG_STAT, 32'h0);
      chk(got[5:4], rows[i].mode);
      chk(got[7], rows[i].hr);
    end
    bus(0, `LDM_REG_DUTY, 32'h0);
    chk(got[11:0] >= 12'h00c && got[11:0] <= 12'h01c, 1);
    bus(0, 4'h2, 32'h0);
    chk(resp_got, 2'h2);
    chk(got, 32'h0);
    bus(1, 4'h1, 32'hf);
    bus(0, `LDM_REG_CTRL, 32'h0);
    chk(got[3:0], 4'h0);
    mode_pin_level <= `LDM_PIN_LOW;
    bus(1, `LDM_REG_CTRL, 32'h8);
    for (int k = 0; k < 2; k++) begin
      high_cyc <= k ? 16'h0014 : 16'h0028;
      per_cyc <= k ? 16'h00c8 : 16'h0190;
      repeat (1000) @(posedge clk);
      gate_count(4096);
      chk(c >= 1580 && c <= 1700, 1);
    end
    mode_pin_level <= `LDM_PIN_MID;
    high_cyc <= 16'h0064;
    per_cyc <= 16'h0190;
    repeat (400) @(posedge clk);
    gate_count(2000);
    chk(c >= 480 && c <= 520, 1);
    start(1'b1);
    bus(0, `LDM_REG_STAT, 32'h0);
    chk(got[6], 1);
    end_of_test();
  end
endmodule // ldm_dimming_ctrl_bench
